// file: wit_regs.vh
// register map, field positions and widths of the watch interval timer
// Notes on behaviour
// (RL1) watch interrupt every half second from main path or subsystem clock
// (RL2) watch and interval functions share one prescaler, separate requests
// (RL3) 9-bit prescaler on watch count clock; 5-bit counter run by mode reg
// (RL4) bit 7 selects count clock: 0 main divided by 128, 1 subsystem
// (RL5) bits 6..4 pick interval 2^4..2^9 periods; software avoids other codes
// (RL6) interval request repeats every selected interval while enabled
// (RL7) bit 0 low disables and clears prescaler and counter; high enables
// (RL8) bits 0 and 1 set start watch count; clearing them clears counter
// (RL9) clearing bit 1 alone clears counter while prescaler keeps running
// (RL10) counter starts after one full prescaler cycle following enable
// (RL11) mode register resets to all zeros
// (RL12) mode register takes single-bit writes and whole-byte writes
// (RL13) software should use subsystem clock when main clock is 5.0 MHz
// (RL14) counter steps once per prescaler cycle; overflow gives one pulse
// (RL15) bits 3 and 2 read zero and ignore writes
`ifndef WIT_REGS_VH
`define WIT_REGS_VH
`define WIT_MODE_ADDR 16'hFF4A
`define WIT_MODE_RESET 8'h00
`define WIT_MODE_WMASK 8'hF3
`define WIT_RDATA_IDLE 8'h00
`define WIT_CLK_SEL_BIT 7
`define WIT_IVL_HI_BIT 6
`define WIT_IVL_LO_BIT 4
`define WIT_RUN_BIT 1
`define WIT_EN_BIT 0
`define WIT_MAIN_DIV_W 7
`define WIT_PRE_W 9
`define WIT_CNT_W 5
`define WIT_IVL_MIN_LOG 4
`define WIT_IVL_MAX_CODE 3'h5
`endif

// file: wit_timer.v
// watch timer with shared interval timer and its mode register
`timescale 1ns/10ps
`include "wit_regs.vh"
module wit_timer #(
  parameter DIV_W = `WIT_MAIN_DIV_W,
  parameter PRE_W = `WIT_PRE_W,
  parameter CNT_W = `WIT_CNT_W
) (
  // clock, reset, enable
  input wire clk_in,
  input wire reset_in,
  input wire ce_in,
  // oscillator pins, asynchronous to clk_in
  input wire main_osc_clk_in,
  input wire sub_osc_clk_in,
  // processor access
  input wire [15:0] cpu_addr_in,
  input wire cpu_wr_byte_in,
  input wire cpu_wr_bit_in,
  input wire [2:0] cpu_bit_sel_in,
  input wire [7:0] cpu_wdata_in,
  input wire cpu_rd_in,
  output wire [7:0] cpu_rdata_out,
  // interrupt requests
  output wire watch_irq_out,
  output wire interval_irq_out
);

  // low mask bits covering one interval; prohibited codes clamp to longest
  function [PRE_W-1:0] wit_ivl_mask;
    input [2:0] code;
    reg [2:0] c;
    begin
      c = (code > `WIT_IVL_MAX_CODE) ? `WIT_IVL_MAX_CODE : code;
      wit_ivl_mask = {PRE_W{1'b1}} >> (PRE_W - `WIT_IVL_MIN_LOG - c);
    end
  endfunction

  // stable level from a three-stage sampler
  function wit_level;
    input [2:0] sync;
    input prev;
    begin
      wit_level = (sync[1] == sync[2]) ? sync[2] : prev;
    end
  endfunction

  // register and read port
  reg [7:0] watch_mode_reg;
  reg [7:0] rdata_reg;
  // pin samplers and main divider
  reg [2:0] main_sync_reg;
  reg [2:0] sub_sync_reg;
  reg main_lvl_reg;
  reg sub_lvl_reg;
  reg [DIV_W-1:0] main_div_reg;
  // timing chain
  reg [PRE_W-1:0] prescaler_reg;
  reg [CNT_W-1:0] counter_reg;
  reg start_wait_reg;
  // request pulses
  reg watch_irq_reg;
  reg interval_irq_reg;

  // mode fields and address decode
  wire count_clock_select = watch_mode_reg[`WIT_CLK_SEL_BIT];
  wire [2:0] interval_select =
    watch_mode_reg[`WIT_IVL_HI_BIT:`WIT_IVL_LO_BIT];
  wire counter_run_control = watch_mode_reg[`WIT_RUN_BIT];
  wire operation_enable_bit = watch_mode_reg[`WIT_EN_BIT];
  wire addr_hit = (cpu_addr_in == `WIT_MODE_ADDR);

  // edges seen once two later stages agree, so glitches do not count
  wire main_lvl_next = wit_level(main_sync_reg, main_lvl_reg);
  wire sub_lvl_next = wit_level(sub_sync_reg, sub_lvl_reg);
  wire main_rise = main_lvl_next & ~main_lvl_reg;
  wire sub_rise = sub_lvl_next & ~sub_lvl_reg;
  wire main_div_wrap = main_rise & (&main_div_reg);

  // (RL4) count clock select
  wire watch_count_clock = count_clock_select ? sub_rise : main_div_wrap;

  // prescaler about to roll over on this tick
  wire pre_wrap = watch_count_clock & (&prescaler_reg);
  // (RL5) interval tap select
  wire [PRE_W-1:0] ivl_mask = wit_ivl_mask(interval_select);
  wire ivl_hit = watch_count_clock &
    ((prescaler_reg & ivl_mask) == ivl_mask);
  // watch counter runs only with both control bits set
  wire counting = operation_enable_bit & counter_run_control;
  // steps on wraps once the first wrap has armed it
  wire cnt_step = counting & pre_wrap & ~start_wait_reg;
  // counter at its last value, so the next step overflows
  wire cnt_last = &counter_reg;

  // strobes qualified by the register address
  wire wr_byte_hit = cpu_wr_byte_in & addr_hit;
  wire wr_bit_hit = cpu_wr_bit_in & addr_hit;
  wire rd_hit = cpu_rd_in & addr_hit;

  // mode register next value; byte write wins over a bit write
  // bit writes to reserved positions fall to the mask below
  reg [7:0] watch_mode_next;
  always @* begin
    watch_mode_next = watch_mode_reg;
    // (RL12) byte and bit writes
    if (wr_byte_hit) begin
      watch_mode_next = cpu_wdata_in;
    end else if (wr_bit_hit) begin
      watch_mode_next[cpu_bit_sel_in] = cpu_wdata_in[0];
    end
    // (RL15) reserved bits zero
    watch_mode_next = watch_mode_next & `WIT_MODE_WMASK;
  end

  // mode register
  always @(posedge clk_in) begin
    if (reset_in) begin
      // (RL11) reset clears mode
      watch_mode_reg <= `WIT_MODE_RESET;
    end else if (ce_in) begin
      watch_mode_reg <= watch_mode_next;
    end
  end

  // read port, idle value when not addressed
  // a read in the same cycle as a write sees the old value
  always @(posedge clk_in) begin
    if (reset_in) begin
      rdata_reg <= `WIT_RDATA_IDLE;
    end else if (ce_in) begin
      if (rd_hit) begin
        rdata_reg <= watch_mode_reg;
      end else begin
        rdata_reg <= `WIT_RDATA_IDLE;
      end
    end
  end

  // subsystem pin sampler; a level counts once stages two and three agree
  always @(posedge clk_in) begin
    if (reset_in) begin
      sub_sync_reg <= 3'h0;
      sub_lvl_reg <= 1'b0;
    end else if (ce_in) begin
      sub_sync_reg <= {sub_sync_reg[1:0], sub_osc_clk_in};
      sub_lvl_reg <= sub_lvl_next;
    end
  end

  // main pin sampler and divider
  // divider runs free: the first main tick after enable may come early
  always @(posedge clk_in) begin
    if (reset_in) begin
      main_sync_reg <= 3'h0;
      main_lvl_reg <= 1'b0;
      main_div_reg <= {DIV_W{1'b0}};
    end else if (ce_in) begin
      main_sync_reg <= {main_sync_reg[1:0], main_osc_clk_in};
      main_lvl_reg <= main_lvl_next;
      if (main_rise) begin
        main_div_reg <= main_div_reg + 1'b1;
      end
    end
  end

  // prescaler and arming flag; disable wipes both so a restart is clean
  always @(posedge clk_in) begin
    if (reset_in) begin
      prescaler_reg <= {PRE_W{1'b0}};
      start_wait_reg <= 1'b1;
    end else if (ce_in) begin
      if (!operation_enable_bit) begin
        // (RL7) disabled clears prescaler
        prescaler_reg <= {PRE_W{1'b0}};
        start_wait_reg <= 1'b1;
      end else begin
        // (RL3) prescaler on count clock
        if (watch_count_clock) begin
          prescaler_reg <= prescaler_reg + 1'b1;
        end
        // (RL10) first wrap only arms
        if (pre_wrap) begin
          start_wait_reg <= 1'b0;
        end
      end
    end
  end

  // watch counter; bit 1 low holds it at zero while the prescaler runs
  // first request after enable is one wrap late, later ones every 32 wraps
  always @(posedge clk_in) begin
    if (reset_in) begin
      counter_reg <= {CNT_W{1'b0}};
    end else if (ce_in) begin
      if (!counting) begin
        // (RL7) (RL8) (RL9) counter held clear
        counter_reg <= {CNT_W{1'b0}};
      end else if (cnt_step) begin
        // (RL14) one step per wrap
        counter_reg <= counter_reg + 1'b1;
      end
    end
  end

  // request pulses; each stands for one enabled cycle only
  always @(posedge clk_in) begin
    if (reset_in) begin
      watch_irq_reg <= 1'b0;
      interval_irq_reg <= 1'b0;
    end else if (ce_in) begin
      // (RL1) (RL14) pulse on overflow
      watch_irq_reg <= cnt_step & cnt_last;
      // (RL2) (RL6) interval request repeats
      interval_irq_reg <= operation_enable_bit & ivl_hit;
    end
  end

  // outputs straight from flops
  assign cpu_rdata_out = rdata_reg;
  assign watch_irq_out = watch_irq_reg;
  assign interval_irq_out = interval_irq_reg;

endmodule // wit_timer

// file: wit_props.sv
// port checker for the watch interval timer
`timescale 1ns/10ps
module wit_props (
  // watched ports
  input wire clk_in,
  input wire reset_in,
  input wire ce_in,
  input wire [15:0] cpu_addr_in,
  input wire cpu_wr_byte_in,
  input wire cpu_wr_bit_in,
  input wire cpu_rd_in,
  input wire [7:0] cpu_wdata_in,
  input wire [7:0] cpu_rdata_out,
  input wire watch_irq_out,
  input wire interval_irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // register hit, counted only while the block is clocked
  wire acc = ce_in && cpu_addr_in == 16'hFF4A;
  chk_rsv_zero: assert property (
    cpu_rdata_out[3:2] == 2'b00) else $error("reserved bits set");
  chk_reset_clear: assert property (
    $fell(reset_in) |-> cpu_rdata_out == 8'h00 && !watch_irq_out
    && !interval_irq_out) else $error("reset left state behind");
  chk_write_back: assert property (
    acc && cpu_wr_byte_in ##1 (!cpu_wr_byte_in && !cpu_wr_bit_in) [*2]
    ##1 acc && cpu_rd_in |=> cpu_rdata_out ==
    ($past(cpu_wdata_in, 4) & 8'hF3)) else $error("read back wrong");
  chk_rdata_idle: assert property (
    ce_in && !(acc && cpu_rd_in) |=> cpu_rdata_out == 8'h00)
    else $error("read data not idle");
  chk_watch_pulse: assert property (
    watch_irq_out |=> !watch_irq_out) else $error("watch pulse long");
  chk_watch_gap: assert property (
    watch_irq_out |=> !watch_irq_out [*8]) else $error("watch too soon");
  chk_ivl_gap: assert property (
    interval_irq_out |=> !interval_irq_out [*8])
    else $error("interval too soon");
  chk_off_quiet: assert property (
    acc && cpu_wr_byte_in && !cpu_wdata_in[0] |=> ##2
    (!interval_irq_out && !watch_irq_out) [*8]) else $error("irq when off");
  // main scenarios reached
  cov_ivl: cover property (interval_irq_out);
  cov_watch: cover property (watch_irq_out);
  cov_read: cover property (acc && cpu_rd_in);
endmodule // wit_props
bind wit_timer wit_props u_props (.clk_in, .reset_in, .ce_in, .cpu_addr_in,
  .cpu_wr_byte_in, .cpu_wr_bit_in, .cpu_rd_in, .cpu_wdata_in,
  .cpu_rdata_out, .watch_irq_out, .interval_irq_out);

// file: tb_top.sv
// self-checking bench for the watch interval timer
`timescale 1ns/10ps
module tb_top;
  logic clk_in = 0, reset_in = 1, wr_byte = 0, wr_bit = 0, rd = 0;
  logic ce = 1;
  logic [15:0] addr = 16'hFF4A;
  logic [2:0] bsel = 3'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [31:0] cyc = 0;
  wire w_irq, i_irq;
  int error_cnt = 0, compares = 0;
  // both oscillators run at 4 clk; DIV_W of 1 keeps the main path short
  wit_timer #(.DIV_W(1)) DUT (.clk_in(clk_in), .reset_in(reset_in),
    .ce_in(ce), .main_osc_clk_in(cyc[1]), .sub_osc_clk_in(cyc[1]),
    .cpu_addr_in(addr), .cpu_wr_byte_in(wr_byte), .cpu_wr_bit_in(wr_bit),
    .cpu_bit_sel_in(bsel), .cpu_wdata_in(wdata), .cpu_rd_in(rd),
    .cpu_rdata_out(rdata), .watch_irq_out(w_irq), .interval_irq_out(i_irq));
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // clock, oscillator phase and hang guard
  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt++;
      end_of_test;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // cycle counts between requests
  task chk_cyc(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t cycles got=%h exp=%h", $time, g, e);
    end
  endtask
  // byte write when bw is high, else bit write of d[0]
  task wr(input logic [15:0] a, input logic bw, input logic [2:0] s,
    input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    bsel <= s;
    wdata <= d;
    wr_byte <= bw;
    wr_bit <= !bw;
    @(posedge clk_in);
    wr_byte <= 0;
    wr_bit <= 0;
  endtask
  task rd8(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1;
    @(posedge clk_in);
    rd <= 0;
    #1 d = rdata;
  endtask
  // interval in clk cycles: 2^(4+code) ticks, 4 clk sub or 8 clk main
  function int per(logic [7:0] m);
    return (16 << m[6:4]) * (m[7] ? 4 : 8);
  endfunction
  // disable first so the prescaler starts clean, then time two pulses
  task meas(input logic [7:0] m);
    int n;
    n = 0;
    wr(16'hFF4A, 1, 0, 8'h00);
    wr(16'hFF4A, 1, 0, m);
    @(posedge i_irq);
    @(posedge clk_in);
    #1;
    while (i_irq !== 1'b1) begin
      @(posedge clk_in);
      #1 n++;
    end
    chk_cyc(n + 1, per(m));
  endtask
  initial begin
    int n;
    logic [31:0] r;
    logic [7:0] d, model;
    r = $urandom(32'hd836);
    repeat (20) @(posedge clk_in);
    reset_in <= 0;
    model = 8'h00;
    rd8(16'hFF4A, d);
    chk(d, 8'h00);
    // a write while the clock enable is low must not land
    @(posedge clk_in);
    ce <= 0;
    wr(16'hFF4A, 1, 0, 8'h83);
    ce <= 1;
    rd8(16'hFF4A, d);
    chk(d, 8'h00);
    // bit 6 kept low so interval codes stay legal
    repeat (16) begin
      r = $urandom;
      if (r[4:2] == 3'h6) r[4:2] = 3'h2;
      wr({15'h7FA5, r[1] & r[0]}, r[0], r[4:2], r[15:8] & 8'hBF);
      if (!r[0]) model[r[4:2]] = r[8];
      else if (!r[1]) model = r[15:8] & 8'hBF;
      model = model & 8'hF3;
      rd8(16'hFF4A, d);
      chk(d, model);
    end
    rd8(16'hFF4B, d);
    chk(d, 8'h00);
    $display("register test done");
    for (int c = 0; c < 6; c++) meas({1'b1, c[2:0], 4'h3});
    meas({2'b00, r[17:16], 4'h1});
    $display("interval test done");
    wr(16'hFF4A, 1, 0, 8'h00);
    // half-second watch taken from the subsystem clock
    wr(16'hFF4A, 1, 0, 8'h83);
    n = 0;
    while (w_irq !== 1'b1) begin
      @(posedge clk_in);
      #1 n++;
    end
    chk({31'h0, n > 67570 && n < 67600}, 32'h1);
    $display("watch test done");
    // a second reset mid-run must clear the mode register again
    @(posedge clk_in);
    reset_in <= 1;
    repeat (2) @(posedge clk_in);
    reset_in <= 0;
    rd8(16'hFF4A, d);
    chk(d, 8'h00);
    $display("reset test done");
    end_of_test;
  end
endmodule // tb_top
